// ### verilog/cmmd_top.sv
`timescale 1ns/1ps
// memory map decoder with nibble-wide lcd ram, high-speed ram and reset vector fetch
// assumes rom contents arrive on rom_rdata combinationally and sfrs live outside
module cmmd_top
  import cmmd_pkg::*;
(
  input  wire logic        sys_clk,         // 25 mhz system clock
  input  wire logic        nrst,            // async reset, active low
  input  wire logic        flash,           // variant strap, 1 = flash
  input  wire logic        req,             // cpu access request
  input  wire logic        we,              // 1 = write
  input  wire logic        stack,           // access is a stack push or pop
  input  wire logic [15:0] addr,            // cpu byte address
  input  wire logic [7:0]  wdata,           // write data
  input  wire logic [7:0]  rom_rdata,       // program memory byte at rom_addr, at addr once prog_cnt_valid is set
  input  wire logic [7:0]  sfr_rdata,       // sfr read data
  output logic      [15:0] rom_addr,        // program memory address
  output logic      [7:0]  rdata,           // read data, one cycle after req
  output logic             rvalid,          // read data valid pulse
  output logic      [2:0]  region,          // region of last access
  output logic             sfr_sel,         // sfr access pulse
  output logic             sfr_we,          // sfr write
  output logic      [7:0]  sfr_addr,        // sfr offset
  output logic      [7:0]  sfr_wdata,       // sfr write data
  output logic             stack_err,       // stack access outside ram
  output logic             vec_hit,         // last access in vector table
  output logic             tbl_call_hit,    // last access in table-call area
  output logic             fix_call_hit,    // last access in fixed-call area
  output logic             greg_hit,        // last access in register banks
  output logic      [15:0] program_counter, // loaded from reset vector
  output logic             prog_cnt_valid,  // program counter loaded
  output logic      [79:0] lcd_segments     // display ram contents
);
  import cmmd_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  cmmd_dec_if dif ();
  logic [15:0] dec_addr;
  cmmd_state_e st_r;
  // the vector fetch borrows the decoder so rom path is shared
  assign dec_addr = (st_r == CMMD_ST_RUN) ? addr : rom_addr;
  cmmd_decode u_dec (
    .addr  (dec_addr),
    .flash (flash),
    .d     (dif)
  );

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [CMMD_LCD_WIDTH-1:0] lcd_mem [CMMD_LCD_DEPTH];
  logic [7:0]                ram_mem [CMMD_RAM_DEPTH];
  logic                      run;
  logic                      acc;
  logic [4:0]                lcd_idx;
  logic [9:0]                ram_idx;
  assign run     = (st_r == CMMD_ST_RUN);
  assign acc     = run && req;
  assign lcd_idx = 5'(addr - CMMD_LCD_LO);
  assign ram_idx = addr[9:0]; // ram top at feffh: low 10 bits index uniquely

  // lcd ram: nibble store, usable as normal ram
  always_ff @(posedge sys_clk) begin
    if (acc && we && dif.region == 3'(CMMD_REG_LCD)) begin
      lcd_mem[lcd_idx] <= wdata[CMMD_LCD_WIDTH-1:0];
    end
  end

  // high-speed ram incl. register banks and stack; unmapped writes dropped
  always_ff @(posedge sys_clk) begin
    if (acc && we && dif.region == 3'(CMMD_REG_RAM)) begin
      ram_mem[ram_idx] <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // reset vector fetch
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r            <= CMMD_ST_VLO;
      rom_addr        <= CMMD_RST_VEC;
      program_counter <= 16'h0000;
      prog_cnt_valid  <= 1'b0;
    end else begin
      case (st_r)
        CMMD_ST_VLO: begin
          program_counter[7:0] <= rom_rdata;
          rom_addr             <= CMMD_RST_VEC + 16'h0001;
          st_r                 <= CMMD_ST_VHI;
        end
        CMMD_ST_VHI: begin
          program_counter[15:8] <= rom_rdata;
          prog_cnt_valid        <= 1'b1;
          st_r                  <= CMMD_ST_RUN;
        end
        default: begin
          if (req) begin
            rom_addr <= addr;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path and status, registered one cycle after the request
  // ----------------------------------------------------------------
  // rom and sfr data are taken as they stand in the request cycle, at the edge that samples req
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= 1'b0;
      if (acc && !we) begin
        rvalid <= 1'b1;
        if (dif.region == 3'(CMMD_REG_ROM)) begin
          rdata <= rom_rdata_now();
        end else if (dif.region == 3'(CMMD_REG_SFR)) begin
          rdata <= sfr_rdata;
        end else if (dif.region == 3'(CMMD_REG_LCD)) begin
          rdata <= {4'h0, lcd_mem[lcd_idx]};
        end else if (dif.region == 3'(CMMD_REG_RAM)) begin
          rdata <= ram_mem[ram_idx];
        end else begin
          rdata <= CMMD_UNDEF_RD;
        end
      end
    end
  end

  // rom answers addr once running while rom_addr follows addr a cycle late; read straight from the port
  function automatic logic [7:0] rom_rdata_now();
    return rom_rdata;
  endfunction

  // sfr strobe and region flags
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      region    <= 3'(CMMD_REG_NONE);
      sfr_sel   <= 1'b0;
      sfr_we    <= 1'b0;
      sfr_addr  <= 8'h00;
      sfr_wdata <= 8'h00;
      stack_err <= 1'b0;
      vec_hit   <= 1'b0;
      tbl_call_hit <= 1'b0;
      fix_call_hit <= 1'b0;
      greg_hit  <= 1'b0;
    end else begin
      sfr_sel <= acc && dif.region == 3'(CMMD_REG_SFR);
      if (acc) begin
        region    <= dif.region;
        sfr_we    <= we;
        sfr_addr  <= addr[7:0];
        sfr_wdata <= wdata;
        stack_err <= stack && dif.region != 3'(CMMD_REG_RAM);
        vec_hit   <= dif.is_vec;
        tbl_call_hit <= dif.is_tbl_call;
        fix_call_hit <= dif.is_fix_call;
        greg_hit  <= dif.is_greg;
      end
    end
  end

  // display feed, flattened for the lcd driver
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lcd_segments <= 80'h0;
    end else begin
      for (int i = 0; i < CMMD_LCD_DEPTH; i++) begin
        lcd_segments[i*CMMD_LCD_WIDTH +: CMMD_LCD_WIDTH] <= lcd_mem[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_cnt_two_cycles;
    @(posedge sys_clk) disable iff (!nrst) $rose(prog_cnt_valid) |-> $past(st_r) == CMMD_ST_VHI;
  endproperty
  a_cnt_two_cycles: assert property (p_cnt_two_cycles) else $error("counter valid without vector fetch");

  property p_cnt_stable;
    @(posedge sys_clk) disable iff (!nrst) prog_cnt_valid && $past(prog_cnt_valid) |-> $stable(program_counter);
  endproperty
  a_cnt_stable: assert property (p_cnt_stable) else $error("program counter moved after load");

  property p_sfr_top;
    @(posedge sys_clk) disable iff (!nrst) acc && addr >= 16'hff00 |=> sfr_sel;
  endproperty
  a_sfr_top: assert property (p_sfr_top) else $error("sfr window not selected");

  property p_sfr_only;
    @(posedge sys_clk) disable iff (!nrst) acc && addr < 16'hff00 |=> !sfr_sel;
  endproperty
  a_sfr_only: assert property (p_sfr_only) else $error("sfr selected below window");

  property p_rom_end;
    @(posedge sys_clk) disable iff (!nrst) acc && addr == 16'h6000 |=> region == (flash ? 3'(CMMD_REG_ROM) : 3'(CMMD_REG_NONE));
  endproperty
  a_rom_end: assert property (p_rom_end) else $error("rom end wrong for variant");

  property p_ram_flash;
    @(posedge sys_clk) disable iff (!nrst) acc && addr == 16'hfb00 |=> region == (flash ? 3'(CMMD_REG_RAM) : 3'(CMMD_REG_NONE));
  endproperty
  a_ram_flash: assert property (p_ram_flash) else $error("ram start wrong for variant");

  property p_lcd_nibble;
    @(posedge sys_clk) disable iff (!nrst) rvalid && region == 3'(CMMD_REG_LCD) |-> rdata[7:4] == 4'h0;
  endproperty
  a_lcd_nibble: assert property (p_lcd_nibble) else $error("lcd ram read wider than 4 bits");

  property p_unmapped;
    @(posedge sys_clk) disable iff (!nrst) rvalid && region == 3'(CMMD_REG_NONE) |-> rdata == CMMD_UNDEF_RD;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not default");

  property p_tbl_call;
    @(posedge sys_clk) disable iff (!nrst) acc && addr >= 16'h0040 && addr <= 16'h007f |=> tbl_call_hit && !vec_hit;
  endproperty
  a_tbl_call: assert property (p_tbl_call) else $error("table-call area misdecoded");

  property p_stack;
    @(posedge sys_clk) disable iff (!nrst) acc && stack && addr == 16'hfe00 |=> !stack_err;
  endproperty
  a_stack: assert property (p_stack) else $error("stack in ram flagged");
endmodule

// ### verilog/cmmd_pkg.sv
// constants for the cpu memory map decoder: region bounds, vector slots, sizes
// assumes the cpu core presents one byte access per cycle on sys_clk
// What this block does
// - decode a flat 64-Kbyte space from 16-bit addresses
// - mask-rom variant: program memory 0000h..5fffh, bytes
// - flash variant: program memory 0000h..7fffh, bytes
// - 0000h..003fh is the vector table for reset and interrupts
// - vector entry: low byte at even address, high byte at odd
// - reset at 0000h, interrupts 0004h..0028h even, break at 003eh
// - 0040h..007fh holds one-byte table-call entry addresses
// - two-byte fixed-call targets lie within 0800h..0fffh
// - high-speed ram fc00h..feffh (mask) or fb00h..feffh (flash)
// - fee0h..feffh holds four banks of eight 8-bit registers
// - stack accesses belong in high-speed ram; one outside it raises stack_err
// - lcd display ram fa59h..fa6ch, twenty 4-bit locations
// - lcd display ram also takes ordinary reads and writes
// - accesses from ff00h upward go to the sfr window
// - reset loads the program counter from bytes 0000h and 0001h
package cmmd_pkg;
  localparam logic [15:0] CMMD_ROM_END_MASK  = 16'h5fff;
  localparam logic [15:0] CMMD_ROM_END_FLASH = 16'h7fff;
  localparam logic [15:0] CMMD_VEC_END       = 16'h003f;
  localparam logic [15:0] CMMD_RST_VEC       = 16'h0000;
  localparam logic [15:0] CMMD_INT_VEC_LO    = 16'h0004;
  localparam logic [15:0] CMMD_INT_VEC_HI    = 16'h0028;
  localparam logic [15:0] CMMD_BREAK_VEC     = 16'h003e;
  localparam logic [15:0] CMMD_TBL_CALL_LO   = 16'h0040;
  localparam logic [15:0] CMMD_TBL_CALL_HI   = 16'h007f;
  localparam logic [15:0] CMMD_FIX_CALL_LO   = 16'h0800;
  localparam logic [15:0] CMMD_FIX_CALL_HI   = 16'h0fff;
  localparam logic [15:0] CMMD_LCD_LO        = 16'hfa59;
  localparam logic [15:0] CMMD_LCD_HI        = 16'hfa6c;
  localparam logic [15:0] CMMD_RAM_LO_MASK   = 16'hfc00;
  localparam logic [15:0] CMMD_RAM_LO_FLASH  = 16'hfb00;
  localparam logic [15:0] CMMD_RAM_HI        = 16'hfeff;
  localparam logic [15:0] CMMD_GREG_LO       = 16'hfee0;
  localparam logic [15:0] CMMD_SFR_LO        = 16'hff00;
  localparam int          CMMD_LCD_DEPTH     = 20;
  localparam int          CMMD_LCD_WIDTH     = 4;
  localparam int          CMMD_RAM_DEPTH     = 1024;
  localparam logic [7:0]  CMMD_UNDEF_RD      = 8'hff;
  typedef enum logic [2:0] {
    CMMD_REG_NONE, CMMD_REG_ROM, CMMD_REG_LCD, CMMD_REG_RAM, CMMD_REG_SFR
  } cmmd_region_e;
  typedef enum {CMMD_ST_VLO, CMMD_ST_VHI, CMMD_ST_RUN} cmmd_state_e;
endpackage

// ### verilog/cmmd_dec_if.sv
`timescale 1ns/1ps
// decoded region and flags passed from the decoder leaf to the top
// assumes a purely combinational producer
interface cmmd_dec_if;
  logic [2:0] region;   // cmmd_region_e code
  logic       is_vec;   // inside vector table
  logic       is_tbl_call; // inside table-call area
  logic       is_fix_call; // inside fixed-call area
  logic       is_greg;     // inside general-register banks
  modport dec (output region, is_vec, is_tbl_call, is_fix_call, is_greg);
  modport use_ (input region, is_vec, is_tbl_call, is_fix_call, is_greg);
endinterface

// ### verilog/cmmd_decode.sv
`timescale 1ns/1ps
// combinational address decoder for the memory map
// assumes the flash strap is stable while addresses are presented
module cmmd_decode
  import cmmd_pkg::*;
(
  input  wire logic [15:0] addr,  // byte address
  input  wire logic        flash, // 1 = flash variant
  cmmd_dec_if.dec          d      // decoded region
);
  logic [15:0] rom_end;
  logic [15:0] ram_lo;
  assign rom_end = flash ? CMMD_ROM_END_FLASH : CMMD_ROM_END_MASK;
  assign ram_lo  = flash ? CMMD_RAM_LO_FLASH : CMMD_RAM_LO_MASK;
  // priority chain; the gap between rom and lcd ram is unmapped
  always_comb begin
    if (addr <= rom_end) begin
      d.region = 3'(CMMD_REG_ROM);
    end else if (addr >= CMMD_LCD_LO && addr <= CMMD_LCD_HI) begin
      d.region = 3'(CMMD_REG_LCD);
    end else if (addr >= ram_lo && addr <= CMMD_RAM_HI) begin
      d.region = 3'(CMMD_REG_RAM);
    end else if (addr >= CMMD_SFR_LO) begin
      d.region = 3'(CMMD_REG_SFR);
    end else begin
      d.region = 3'(CMMD_REG_NONE);
    end
  end
  assign d.is_vec   = (addr <= CMMD_VEC_END);
  assign d.is_tbl_call = (addr >= CMMD_TBL_CALL_LO && addr <= CMMD_TBL_CALL_HI);
  assign d.is_fix_call = (addr >= CMMD_FIX_CALL_LO && addr <= CMMD_FIX_CALL_HI);
  assign d.is_greg  = (addr >= CMMD_GREG_LO && addr <= CMMD_RAM_HI);
endmodule

// ### sim/cmmd_rom_model.sv
`timescale 1ns/1ps
// program memory and sfr read side seen by the decoder, standing in for the cpu core's far side
// assumes rom_rdata is combinational and follows rom_addr until the counter is loaded, addr afterwards
module cmmd_rom_model
  import cmmd_pkg::*;
(
  input  wire logic        sys_clk,   // system clock
  input  wire logic        prog_cnt_valid, // run mode flag from the decoder
  input  wire logic [15:0] addr,      // cpu byte address
  input  wire logic [15:0] rom_addr,  // fetch address during vector load
  output logic      [7:0]  rom_rdata, // program byte
  output logic      [7:0]  sfr_rdata  // sfr read byte
);
  // ----------------------------------------
  // contents
  // ----------------------------------------
  logic [7:0]  junk_r; // changes every cycle so a stale read never passes
  logic [15:0] fa;
  // plain always: the start value comes from the initial block below
  always @(posedge sys_clk) begin
    junk_r <= junk_r + 8'h35;
  end
  initial junk_r = 8'h00;
  assign fa = prog_cnt_valid ? addr : rom_addr;
  // low byte of each vector at the even address, high byte at the odd one
  assign rom_rdata = fa[7:0] ^ fa[15:8] ^ 8'h5a;
  // every address from ff00h up is driven, the rest read as a moving pattern
  assign sfr_rdata = (addr >= 16'hff00) ? ~addr[7:0] : junk_r;
endmodule

// ### sim/cmmd_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the memory map decoder
// assumes the rom model answers reads combinationally and one access per cycle
module cmmd_tb_top;
  import cmmd_pkg::*;
  logic        sys_clk, nrst, flash, req, we, stack;
  logic [15:0] addr, rom_addr, program_counter;
  logic [7:0]  wdata, rom_rdata, sfr_rdata, rdata, sfr_addr, sfr_wdata;
  logic [2:0]  region;
  logic        rvalid, sfr_sel, sfr_we, stack_err, vec_hit, tbl_call_hit, fix_call_hit, greg_hit, prog_cnt_valid;
  logic [79:0] lcd_segments;
  int          err_count, checks_done;
  cmmd_top cmmd_top_i (.sys_clk(sys_clk), .nrst(nrst), .flash(flash), .req(req), .we(we), .stack(stack),
    .addr(addr), .wdata(wdata), .rom_rdata(rom_rdata), .sfr_rdata(sfr_rdata), .rom_addr(rom_addr),
    .rdata(rdata), .rvalid(rvalid), .region(region), .sfr_sel(sfr_sel), .sfr_we(sfr_we),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .stack_err(stack_err), .vec_hit(vec_hit),
    .tbl_call_hit(tbl_call_hit), .fix_call_hit(fix_call_hit), .greg_hit(greg_hit),
    .program_counter(program_counter), .prog_cnt_valid(prog_cnt_valid), .lcd_segments(lcd_segments));
  cmmd_rom_model cmmd_rom_model_i (.sys_clk(sys_clk), .prog_cnt_valid(prog_cnt_valid), .addr(addr),
    .rom_addr(rom_addr), .rom_rdata(rom_rdata), .sfr_rdata(sfr_rdata));
  // ----------------------------------------
  // clock, helpers
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] romv(input logic [15:0] a);
    romv = a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  task automatic ck(input logic [79:0] got, input logic [79:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic give_verdict;
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // reset with a chosen strap; the vector load takes exactly two edges
  task automatic rst(input logic fl);
    nrst = 1'b0; flash = fl; req = 1'b0; addr = 16'h0000;
    repeat (8) @(posedge sys_clk);
    #1 nrst = 1'b1;
    @(posedge sys_clk);
    #1 ck(prog_cnt_valid, 1'b0, "counter valid too early");
    ck(rom_addr, CMMD_RST_VEC + 16'h0001, "vector high byte address");
    @(posedge sys_clk);
    #1 ck(prog_cnt_valid, 1'b1, "counter not valid");
    ck(program_counter, {romv(16'h0001), romv(16'h0000)}, "reset vector");
  endtask
  // req stays up between back-to-back calls; idle drops it for one edge
  task automatic acc(input logic w, input logic s, input logic [15:0] a, input logic [7:0] d);
    req = 1'b1; we = w; stack = s; addr = a; wdata = d;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic idle;
    req = 1'b0; we = 1'b0; stack = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [2:0] r);
    acc(1'b0, 1'b0, a, 8'h00);
    ck(rvalid, 1'b1, "no rvalid");
    ck(rdata, e, "read data");
    ck(region, r, "region");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_rom;
    rst(1'b0);
    rd(16'h5fff, romv(16'h5fff), 3'd1);
    ck(rom_addr, 16'h5fff, "fetch address");
    rd(16'h6000, 8'hff, 3'd0);
    idle;
    rst(1'b1);
    rd(16'h7fff, romv(16'h7fff), 3'd1);
    rd(16'h8000, 8'hff, 3'd0);
    acc(1'b1, 1'b0, 16'hfb00, 8'h96);
    rd(16'hfb00, 8'h96, 3'd3);
    idle;
  endtask
  task automatic t_vec;
    logic [15:0] al [10] = '{16'h0000, 16'h003e, 16'h003f, 16'h0040, 16'h007f, 16'h0080, 16'h07ff,
                             16'h0800, 16'h0fff, 16'h1000};
    logic [2:0]  fl [10] = '{3'b100, 3'b100, 3'b100, 3'b010, 3'b010, 3'b000, 3'b000, 3'b001, 3'b001, 3'b000};
    rst(1'b0);
    for (int i = 0; i < 10; i++) begin
      rd(al[i], romv(al[i]), 3'd1);
      ck({vec_hit, tbl_call_hit, fix_call_hit}, fl[i], "area flags");
    end
    idle;
  endtask
  task automatic t_ram;
    acc(1'b1, 1'b0, 16'hfeff, 8'h3c);
    acc(1'b1, 1'b0, 16'hfaff, 8'hc3); // unmapped here, same low ten bits as feff
    rd(16'hfeff, 8'h3c, 3'd3);
    ck(greg_hit, 1'b1, "bank hit");
    rd(16'hfa6d, 8'hff, 3'd0);
    idle;
    acc(1'b1, 1'b0, 16'hfee0, 8'h21);
    rd(16'hfee0, 8'h21, 3'd3);
    ck(greg_hit, 1'b1, "bank low edge");
    acc(1'b1, 1'b0, 16'hfedf, 8'h5e);
    rd(16'hfedf, 8'h5e, 3'd3);
    ck(greg_hit, 1'b0, "below banks");
    rd(16'hfbff, 8'hff, 3'd0);
    acc(1'b1, 1'b0, 16'hfc00, 8'h11);
    rd(16'hfc00, 8'h11, 3'd3);
    idle;
  endtask
  task automatic t_stack;
    acc(1'b1, 1'b1, 16'hfc10, 8'h42);
    ck(stack_err, 1'b0, "stack in ram");
    ck(rvalid, 1'b0, "rvalid on a write");
    acc(1'b0, 1'b1, 16'hfc10, 8'h00);
    ck(rdata, 8'h42, "stack pop");
    acc(1'b0, 1'b1, 16'hfa00, 8'h00);
    ck(stack_err, 1'b1, "stack outside ram");
    idle;
  endtask
  task automatic t_lcd;
    acc(1'b1, 1'b0, 16'hfa59, 8'ha5);
    acc(1'b1, 1'b0, 16'hfa6c, 8'h0e);
    // the display feed trails the write edge by one clock
    ck(lcd_segments[3:0], 4'h5, "lcd first nibble");
    rd(16'hfa59, 8'h05, 3'd2);
    ck(lcd_segments[79:76], 4'he, "lcd last nibble");
    rd(16'hfa6c, 8'h0e, 3'd2);
    rd(16'hfa58, 8'hff, 3'd0);
    rd(16'hfa6d, 8'hff, 3'd0);
    idle;
  endtask
  task automatic t_sfr;
    acc(1'b1, 1'b0, 16'hff10, 8'h77);
    ck({sfr_sel, sfr_we, sfr_addr, sfr_wdata}, {2'b11, 8'h10, 8'h77}, "sfr write");
    ck(region, 3'd4, "sfr region");
    rd(16'hff20, 8'hdf, 3'd4);
    ck({sfr_sel, sfr_we, sfr_addr}, {2'b10, 8'h20}, "sfr read");
    // a 16-bit sfr write leaves as two bytes, even address first
    acc(1'b1, 1'b0, 16'hff22, 8'h34);
    ck({sfr_addr, sfr_wdata}, {8'h22, 8'h34}, "sfr pair low byte");
    acc(1'b1, 1'b0, 16'hff23, 8'h12);
    ck({sfr_sel, sfr_addr, sfr_wdata}, {1'b1, 8'h23, 8'h12}, "sfr pair high byte");
    idle;
    ck(sfr_sel, 1'b0, "sfr pulse length");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    err_count = 0; checks_done = 0; we = 1'b0;
    stack = 1'b0; wdata = 8'h00;
    t_rom();
    t_vec();
    t_ram();
    t_stack();
    t_lcd();
    t_sfr();
    give_verdict();
  end
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule
